// >>> rtl/speed_quantize.sv
// Clamps a speed to the legal range and rounds it down to the step grid
`timescale 1ns/1ps
`default_nettype none
module speed_quantize (
  input  wire logic [15:0] rpm_in,
  output logic      [15:0] rpm_out,
  output logic             clamped
);
  logic [15:0] lim;

  always_comb begin
    lim     = rpm_in;
    clamped = 1'b0;
    if (rpm_in > speed_req_pkg::RPM_MAX) begin
      lim     = speed_req_pkg::RPM_MAX;
      clamped = 1'b1;
    end else if (rpm_in < speed_req_pkg::RPM_MIN) begin
      lim = speed_req_pkg::RPM_MIN;
    end
    rpm_out = 16'((lim / speed_req_pkg::RPM_STEP) * speed_req_pkg::RPM_STEP);
  end
endmodule // speed_quantize
`default_nettype wire

// >>> rtl/speed_ramp.sv
// Moves the commanded speed toward the target by a fixed step per tick
`timescale 1ns/1ps
`default_nettype none
module speed_ramp (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tick,
  input  wire logic [15:0] target,
  input  wire logic [15:0] step,
  output logic      [15:0] cur_q
);
  // A step of zero freezes the speed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_q <= speed_req_pkg::RPM_MIN;
    end else if (tick && step != 16'h0000) begin
      if (cur_q < target) begin
        cur_q <= (16'(target - cur_q) > step) ? 16'(cur_q + step) : target;
      end else if (cur_q > target) begin
        cur_q <= (16'(cur_q - target) > step) ? 16'(cur_q - step) : target;
      end
    end
  end
endmodule // speed_ramp
`default_nettype wire

// >>> rtl/speed_req_pkg.sv
// Constants and types shared by the working speed request decoder
package speed_req_pkg;

  localparam int          ADDR_W       = 8;
  // Request frame layout
  localparam logic [28:0] CAN_ID       = 29'h18EF71C9;
  localparam int          ACT_BIT      = 0;
  localparam int          SPD_LSB      = 32;
  localparam int          SPD_W        = 16;
  // Speed figures in rpm
  localparam logic [15:0] RPM_MIN      = 16'h03E8;
  localparam logic [15:0] RPM_MAX      = 16'h0ED8;
  localparam logic [15:0] RPM_STEP     = 16'h0064;
  localparam logic [15:0] RPM_HOLD_MIN = 16'h0514;
  localparam logic [15:0] RPM_BYPASS   = 16'h04B0;
  localparam logic [15:0] RPM_STAGE0   = 16'h03E8;
  localparam logic [15:0] RPM_STAGE1   = 16'h05DC;
  localparam logic [15:0] RPM_STAGE2   = 16'h07D0;
  // Timing: one ramp and timeout tick per millisecond
  localparam int          CLK_NS       = 10;
  localparam int          TICK_NS      = 1000000;
  localparam int          TICK_CYC_DEF = TICK_NS / CLK_NS;
  // Register offsets
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_RAMP     = 8'h04;
  localparam logic [7:0]  OFS_SETP     = 8'h08;
  localparam logic [7:0]  OFS_TMO      = 8'h0C;
  localparam logic [7:0]  OFS_STAT     = 8'h10;
  localparam logic [7:0]  OFS_IRQ      = 8'h14;
  localparam logic [7:0]  OFS_MASK     = 8'h18;
  localparam logic [7:0]  OFS_TGT      = 8'h1C;
  // Control fields
  localparam int          CTRL_W       = 6;
  localparam int          CTRL_EN      = 0;
  localparam int          CTRL_VAR     = 1;
  localparam int          CTRL_R250    = 2;
  localparam int          CTRL_FLEET   = 3;
  localparam int          CTRL_STG     = 4;
  // Status fields
  localparam int          STAT_SRC     = 16;
  localparam int          STAT_BYP     = 18;
  localparam int          STAT_LOW     = 19;
  // Interrupt bits
  localparam int          IRQ_W        = 4;
  localparam int          IRQ_FRAME    = 0;
  localparam int          IRQ_FAIL     = 1;
  localparam int          IRQ_BYP      = 2;
  localparam int          IRQ_CLAMP    = 3;
  // Reset values
  localparam logic [5:0]  CTRL_RST     = 6'h00;
  localparam logic [15:0] RAMP_RST     = 16'h0000;
  localparam logic [15:0] SETP_RST     = 16'h03E8;
  localparam logic [15:0] TMO_RST      = 16'h0064;
  localparam logic [3:0]  MASK_RST     = 4'h0;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {
    SRC_OFF   = 2'b00,
    SRC_WIRED = 2'b01,
    SRC_CAN   = 2'b10
  } src_t;

  typedef struct packed {
    logic        valid;
    logic        ext;
    logic [28:0] id;
    logic [63:0] data;
  } can_frame_t;

endpackage

// >>> rtl/speed_request_decoder.sv
// Working speed request decoder with register slave and interrupt
// How it works
// - Only extended frames with the request identifier are accepted; bit rate is selectable.
// - Activation is payload bit 0; target rpm is payload bits 47..32.
// - While the CAN request is active, wired up/down inputs are ignored.
// - Wired control returns when activation clears or the message fails.
// - Commanded speed never exceeds 3800 rpm.
// - Variable option sets 1000 to 3800 rpm in 100 rpm steps.
// - Fixed option offers only 1000, 1500 and 2000 rpm.
// - A ramp step of zero holds the commanded speed.
// - Speeds below 1300 rpm are flagged as not guaranteed.
// - After reset all speed parameters sit at safe low values.
// - An engine protection limit may lower the commanded speed.
// - Commanding above 1200 rpm switches off an active ignition bypass.
// - The fleet option forces the 250 kbit/s rate.
`timescale 1ns/1ps
`default_nettype none
module speed_request_decoder #(
  parameter int unsigned TICK_CYC = speed_req_pkg::TICK_CYC_DEF
) (
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [speed_req_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                       s_axi_awprot,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  output logic      [1:0]                       s_axi_bresp,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  input  wire logic [speed_req_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                       s_axi_arprot,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  output logic      [31:0]                      s_axi_rdata,
  output logic      [1:0]                       s_axi_rresp,
  input  wire speed_req_pkg::can_frame_t        can_rx,
  input  wire logic                             speed_up,
  input  wire logic                             speed_down,
  input  wire logic                             bypass_on,
  input  wire logic [15:0]                      eng_limit_rpm,
  output logic      [15:0]                      rpm_cmd,
  output logic                                  can_rate_250,
  output logic                                  bypass_active,
  output logic                                  low_speed,
  output logic                                  irq
);

  localparam int TW = $clog2(TICK_CYC);

  localparam int CTRL_W_L = speed_req_pkg::CTRL_W;
  logic [CTRL_W_L-1:0] ctrl_q;
  logic [15:0]                    ramp_q;
  logic [15:0]                    setp_q;
  logic [15:0]                    tmo_q;
  logic [speed_req_pkg::IRQ_W-1:0] irq_q;
  logic [speed_req_pkg::IRQ_W-1:0] mask_q;
  logic [speed_req_pkg::IRQ_W-1:0] ev;
  speed_req_pkg::src_t            src_q;
  logic [15:0]                    can_spd_q;
  logic [TW-1:0]                  tick_cnt_q;
  logic                           tick;
  logic [15:0]                    ms_q;
  logic                           byp_q;
  logic [15:0]                    rpm_q;
  logic                           en;
  logic                           var_mode;
  logic                           frame_hit;
  logic                           frame_act;
  logic [15:0]                    frame_spd;
  logic                           fail;
  logic [15:0]                    tgt_raw;
  logic [15:0]                    tgt;
  logic [15:0]                    ramp_cur;
  logic                           aw_hold_q;
  logic [speed_req_pkg::ADDR_W-1:0] aw_addr_q;
  logic                           w_hold_q;
  logic [31:0]                    w_data_q;
  logic [3:0]                     w_strb_q;
  logic                           bvalid_q;
  logic [1:0]                     bresp_q;
  logic                           rvalid_q;
  logic [31:0]                    rdata_q;
  logic [1:0]                     rresp_q;
  logic                           do_wr;
  logic [31:0]                    rd_val;
  logic                           rd_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode

  assign en        = ctrl_q[speed_req_pkg::CTRL_EN];
  assign var_mode  = ctrl_q[speed_req_pkg::CTRL_VAR];
  assign frame_act = can_rx.data[speed_req_pkg::ACT_BIT];
  assign frame_spd = can_rx.data[speed_req_pkg::SPD_LSB +: speed_req_pkg::SPD_W];
  // Requests only count in the variable option
  assign frame_hit = can_rx.valid && can_rx.ext && (can_rx.id == speed_req_pkg::CAN_ID)
                     && en && var_mode;
  assign can_rate_250 = ctrl_q[speed_req_pkg::CTRL_R250] || ctrl_q[speed_req_pkg::CTRL_FLEET];

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and message timeout

  assign tick = (tick_cnt_q == TW'(TICK_CYC - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= TW'(tick_cnt_q + 1'b1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_q <= 16'h0000;
    end else if (frame_hit || src_q != speed_req_pkg::SRC_CAN) begin
      ms_q <= 16'h0000;
    end else if (tick && ms_q != 16'hFFFF) begin
      ms_q <= 16'(ms_q + 16'h0001);
    end
  end

  assign fail = (src_q == speed_req_pkg::SRC_CAN) && (ms_q >= tmo_q);

  ////////////////////////////////////////////////////////////////////////////
  // Command source

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= speed_req_pkg::SRC_OFF;
    end else begin
      case (src_q)
        speed_req_pkg::SRC_OFF: begin
          if (en) begin
            src_q <= speed_req_pkg::SRC_WIRED;
          end
        end
        speed_req_pkg::SRC_WIRED: begin
          if (!en) begin
            src_q <= speed_req_pkg::SRC_OFF;
          end else if (frame_hit && frame_act) begin
            src_q <= speed_req_pkg::SRC_CAN;
          end
        end
        speed_req_pkg::SRC_CAN: begin
          if (!en || !var_mode) begin
            src_q <= en ? speed_req_pkg::SRC_WIRED : speed_req_pkg::SRC_OFF;
          end else if (frame_hit) begin
            src_q <= frame_act ? speed_req_pkg::SRC_CAN : speed_req_pkg::SRC_WIRED;
          end else if (fail) begin
            src_q <= speed_req_pkg::SRC_WIRED;
          end
        end
        default: begin
          src_q <= speed_req_pkg::SRC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      can_spd_q <= speed_req_pkg::RPM_MIN;
    end else if (frame_hit && frame_act) begin
      can_spd_q <= frame_spd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers and wired setpoint

  assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= speed_req_pkg::CTRL_RST;
      ramp_q <= speed_req_pkg::RAMP_RST;
      setp_q <= speed_req_pkg::SETP_RST;
      tmo_q  <= speed_req_pkg::TMO_RST;
      mask_q <= speed_req_pkg::MASK_RST;
    end else if (do_wr) begin
      case (aw_addr_q)
        speed_req_pkg::OFS_CTRL: ctrl_q <= CTRL_W_L'(merge(32'(ctrl_q), w_data_q, w_strb_q));
        speed_req_pkg::OFS_RAMP: ramp_q <= 16'(merge(32'(ramp_q), w_data_q, w_strb_q));
        speed_req_pkg::OFS_SETP: setp_q <= 16'(merge(32'(setp_q), w_data_q, w_strb_q));
        speed_req_pkg::OFS_TMO:  tmo_q  <= 16'(merge(32'(tmo_q), w_data_q, w_strb_q));
        speed_req_pkg::OFS_MASK: mask_q <= 4'(merge(32'(mask_q), w_data_q, w_strb_q));
        default: begin
        end
      endcase
    end else if (src_q == speed_req_pkg::SRC_WIRED && (speed_up ^ speed_down)) begin
      if (var_mode) begin
        if (speed_up && setp_q <= 16'(speed_req_pkg::RPM_MAX - speed_req_pkg::RPM_STEP)) begin
          setp_q <= 16'(setp_q + speed_req_pkg::RPM_STEP);
        end else if (speed_down && setp_q >= 16'(speed_req_pkg::RPM_MIN + speed_req_pkg::RPM_STEP)) begin
          setp_q <= 16'(setp_q - speed_req_pkg::RPM_STEP);
        end
      end else begin
        if (speed_up && ctrl_q[speed_req_pkg::CTRL_STG +: 2] < 2'h2) begin
          ctrl_q[speed_req_pkg::CTRL_STG +: 2] <= 2'(ctrl_q[speed_req_pkg::CTRL_STG +: 2] + 2'h1);
        end else if (speed_down && ctrl_q[speed_req_pkg::CTRL_STG +: 2] != 2'h0) begin
          ctrl_q[speed_req_pkg::CTRL_STG +: 2] <= 2'(ctrl_q[speed_req_pkg::CTRL_STG +: 2] - 2'h1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target, ramp and output

  always_comb begin
    tgt_raw = setp_q;
    if (src_q == speed_req_pkg::SRC_CAN) begin
      tgt_raw = can_spd_q;
    end else if (!var_mode) begin
      case (ctrl_q[speed_req_pkg::CTRL_STG +: 2])
        2'h0:    tgt_raw = speed_req_pkg::RPM_STAGE0;
        2'h1:    tgt_raw = speed_req_pkg::RPM_STAGE1;
        default: tgt_raw = speed_req_pkg::RPM_STAGE2;
      endcase
    end
  end

  // Clamp and grid the target
  speed_quantize u_quant (
    .rpm_in  (tgt_raw),
    .rpm_out (tgt),
    .clamped ()
  );

  speed_ramp u_ramp (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick),
    .target  (tgt),
    .step    (ramp_q),
    .cur_q   (ramp_cur)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || src_q == speed_req_pkg::SRC_OFF) begin
      rpm_q <= 16'h0000;
    end else begin
      rpm_q <= (ramp_cur < eng_limit_rpm) ? ramp_cur : eng_limit_rpm;
    end
  end

  assign rpm_cmd   = rpm_q;
  assign low_speed = (rpm_q != 16'h0000) && (rpm_q < speed_req_pkg::RPM_HOLD_MIN);

  // Hardware clear wins: a bypass cannot be held at high speed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byp_q <= 1'b0;
    end else if (rpm_q > speed_req_pkg::RPM_BYPASS) begin
      byp_q <= 1'b0;
    end else if (bypass_on) begin
      byp_q <= 1'b1;
    end
  end

  assign bypass_active = byp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  always_comb begin
    ev = '0;
    ev[speed_req_pkg::IRQ_FRAME] = frame_hit;
    ev[speed_req_pkg::IRQ_FAIL]  = fail && !frame_hit;
    ev[speed_req_pkg::IRQ_BYP]   = byp_q && (rpm_q > speed_req_pkg::RPM_BYPASS);
    ev[speed_req_pkg::IRQ_CLAMP] = frame_hit && frame_act && (frame_spd > speed_req_pkg::RPM_MAX);
  end

  // New events win over a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= '0;
    end else if (do_wr && aw_addr_q == speed_req_pkg::OFS_IRQ && w_strb_q[0]) begin
      irq_q <= (irq_q & ~w_data_q[speed_req_pkg::IRQ_W-1:0]) | ev;
    end else begin
      irq_q <= irq_q | ev;
    end
  end

  assign irq = |(irq_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready  = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_wr) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= speed_req_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (aw_addr_q[1:0] == 2'b00 && aw_addr_q <= speed_req_pkg::OFS_TGT)
                  ? speed_req_pkg::RESP_OKAY : speed_req_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      speed_req_pkg::OFS_CTRL: rd_val = 32'(ctrl_q);
      speed_req_pkg::OFS_RAMP: rd_val = 32'(ramp_q);
      speed_req_pkg::OFS_SETP: rd_val = 32'(setp_q);
      speed_req_pkg::OFS_TMO:  rd_val = 32'(tmo_q);
      speed_req_pkg::OFS_STAT: begin
        rd_val[15:0] = rpm_q;
        rd_val[speed_req_pkg::STAT_SRC +: 2] = src_q;
        rd_val[speed_req_pkg::STAT_BYP] = byp_q;
        rd_val[speed_req_pkg::STAT_LOW] = low_speed;
      end
      speed_req_pkg::OFS_IRQ:  rd_val = 32'(irq_q);
      speed_req_pkg::OFS_MASK: rd_val = 32'(mask_q);
      speed_req_pkg::OFS_TGT:  rd_val = 32'(tgt);
      default:                 rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= speed_req_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_ok ? speed_req_pkg::RESP_OKAY : speed_req_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_WRONG_ID_IGNORED: assert property (
    (src_q == speed_req_pkg::SRC_WIRED && can_rx.valid && can_rx.id != speed_req_pkg::CAN_ID)
    |=> src_q != speed_req_pkg::SRC_CAN)
    else $error("foreign frame started CAN control");

  AST_WIRED_IGNORED: assert property (
    (src_q == speed_req_pkg::SRC_CAN && !do_wr) |=> $stable(setp_q))
    else $error("wired input moved setpoint under CAN control");

  AST_RELEASE: assert property (
    (src_q == speed_req_pkg::SRC_CAN && en && var_mode && frame_hit && !frame_act)
    |=> src_q == speed_req_pkg::SRC_WIRED)
    else $error("cleared activation kept CAN control");

  AST_FAIL_RELEASE: assert property (
    (fail && en && var_mode && !frame_hit) |=> src_q == speed_req_pkg::SRC_WIRED ##1 !fail)
    else $error("message failure kept CAN control");

  AST_MAX_SPEED: assert property (
    rpm_q <= speed_req_pkg::RPM_MAX && tgt <= speed_req_pkg::RPM_MAX)
    else $error("speed above maximum");

  AST_GRID: assert property (
    tgt >= speed_req_pkg::RPM_MIN && (tgt % speed_req_pkg::RPM_STEP) == 16'h0000)
    else $error("target off the step grid");

  AST_STAGES: assert property (
    (!var_mode && src_q == speed_req_pkg::SRC_WIRED) |->
    (tgt == speed_req_pkg::RPM_STAGE0 || tgt == speed_req_pkg::RPM_STAGE1 || tgt == speed_req_pkg::RPM_STAGE2))
    else $error("fixed option target not a stage");

  AST_RAMP_HOLD: assert property (
    (ramp_q == 16'h0000) [*2] |-> $stable(ramp_cur))
    else $error("speed moved with zero ramp");

  AST_LIMIT: assert property (
    (src_q != speed_req_pkg::SRC_OFF) |=> rpm_q <= $past(eng_limit_rpm))
    else $error("engine limit exceeded");

  AST_BYPASS_OFF: assert property (
    (rpm_q > speed_req_pkg::RPM_BYPASS) |=> !byp_q)
    else $error("bypass stayed on above threshold");

  AST_FLEET_RATE: assert property (
    ctrl_q[speed_req_pkg::CTRL_FLEET] |-> can_rate_250)
    else $error("fleet option without 250 kbit rate");

  AST_CLAMP: assert property (
    (frame_hit && frame_act && frame_spd > speed_req_pkg::RPM_MAX && !do_wr)
    |=> src_q == speed_req_pkg::SRC_CAN && tgt == speed_req_pkg::RPM_MAX)
    else $error("high CAN target not clamped");

endmodule // speed_request_decoder
`default_nettype wire

// >>> verif/can_partner.sv
// Far-side controller model that sends target speed frames
`timescale 1ns/1ps
`default_nettype none
module can_partner (
  input  wire logic                 aclk,
  input  wire logic                 send,
  input  wire logic                 act,
  input  wire logic [15:0]          rpm,
  input  wire logic                 bad_id,
  output speed_req_pkg::can_frame_t frame
);
  initial frame = '0;
  always @(posedge aclk) begin
    frame.ext   <= 1'h1;
    frame.id    <= speed_req_pkg::CAN_ID ^ 29'(bad_id);
    frame.valid <= send;
    if (send) frame.data <= {16'h0000, rpm, 31'h00000000, act};
    else frame.data <= ~frame.data;
  end
endmodule // can_partner
`default_nettype wire

// >>> verif/speed_request_decoder_bench.sv
// Self-checking bench for the working speed request decoder
`timescale 1ns/1ps
`default_nettype none
module speed_request_decoder_bench;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, speed_up = 0, speed_down = 0, bypass_on = 0, send = 0, act = 0, bad_id = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_q;
  logic [15:0] eng_limit_rpm = 16'hFFFF, rpm = 0, rpm_cmd;
  logic [1:0]  resp_q, s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        can_rate_250, bypass_active, low_speed, irq;
  speed_req_pkg::can_frame_t can_rx;
  int err_count = 0, compares = 0;
  speed_request_decoder #(.TICK_CYC(10)) i_speed_request_decoder (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .can_rx,
    .speed_up, .speed_down, .bypass_on, .eng_limit_rpm, .rpm_cmd, .can_rate_250, .bypass_active, .low_speed, .irq);
  can_partner i_can_partner (.aclk, .send, .act, .rpm, .bad_id, .frame(can_rx));
  initial forever #5 aclk = ~aclk;
  task automatic report_and_stop;
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) break;
    end
    if (!s_axi_bvalid) err_count++;
    resp_q = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) break;
    end
    if (!s_axi_rvalid) err_count++;
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic send_frame(input logic [15:0] r);
    @(posedge aclk);
    send <= 1'h1;
    act <= 1'h1;
    rpm <= r;
    @(posedge aclk);
    send <= 1'h0;
    repeat (3) @(posedge aclk);
  endtask
  // One-cycle pulse on {bypass_on, speed_down, speed_up}
  task automatic pulse(input logic [2:0] m);
    @(posedge aclk);
    {bypass_on, speed_down, speed_up} <= m;
    @(posedge aclk);
    {bypass_on, speed_down, speed_up} <= 3'h0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_reset;
    chk(rpm_cmd, 0, "rpm after reset");
    rd(speed_req_pkg::OFS_SETP);
    chk(rd_q, 32'h3E8, "setpoint reset");
    rd(8'h20);
    chk(resp_q, speed_req_pkg::RESP_SLVERR, "unmapped read");
    wr(8'h22, 32'h0);
    chk(resp_q, speed_req_pkg::RESP_SLVERR, "unaligned write");
  endtask
  task automatic t_can;
    wr(speed_req_pkg::OFS_CTRL, 32'h3);
    chk(resp_q, speed_req_pkg::RESP_OKAY, "write resp");
    bad_id <= 1'h1;
    send_frame(16'h0BB8);
    bad_id <= 1'h0;
    rd(speed_req_pkg::OFS_STAT);
    chk(rd_q[17:16], 2'h1, "foreign id taken");
    send_frame(16'h07D0);
    rd(speed_req_pkg::OFS_TGT);
    chk(rd_q, 32'h7D0, "can target");
    repeat (100) @(posedge aclk);
    chk(rpm_cmd, 16'h03E8, "zero ramp moved");
    wr(speed_req_pkg::OFS_RAMP, 32'h64);
    repeat (150) @(posedge aclk);
    chk(rpm_cmd, 16'h07D0, "ramp end");
    pulse(3'h1);
    rd(speed_req_pkg::OFS_SETP);
    chk(rd_q, 32'h3E8, "wired step taken");
    pulse(3'h4);
    chk(bypass_active, 1'h0, "bypass kept");
  endtask
  task automatic t_clamp;
    send_frame(16'h1388);
    rd(speed_req_pkg::OFS_TGT);
    chk(rd_q, 32'hED8, "clamp");
    wr(speed_req_pkg::OFS_MASK, 32'h8);
    chk(irq, 1'h1, "irq low");
    wr(speed_req_pkg::OFS_IRQ, 32'hF);
    chk(irq, 1'h0, "irq stuck");
    repeat (300) @(posedge aclk);
    chk(rpm_cmd, 16'h0ED8, "max rpm");
    eng_limit_rpm <= 16'h04B0;
    repeat (3) @(posedge aclk);
    chk(rpm_cmd, 16'h04B0, "limit");
    chk(low_speed, 1'h1, "low flag");
    pulse(3'h4);
    chk(bypass_active, 1'h1, "bypass not set");
    eng_limit_rpm <= 16'hFFFF;
    repeat (3) @(posedge aclk);
    chk(bypass_active, 1'h0, "bypass not cleared");
  endtask
  task automatic t_fail;
    repeat (1200) @(posedge aclk);
    rd(speed_req_pkg::OFS_STAT);
    chk(rd_q[17:16], 2'h1, "no fallback");
    pulse(3'h1);
    rd(speed_req_pkg::OFS_SETP);
    chk(rd_q, 32'h44C, "wired step lost");
  endtask
  task automatic t_fixed;
    wr(speed_req_pkg::OFS_CTRL, 32'h29);
    chk(can_rate_250, 1'h1, "fleet rate");
    rd(speed_req_pkg::OFS_TGT);
    chk(rd_q, 32'h7D0, "stage 2");
    pulse(3'h2);
    rd(speed_req_pkg::OFS_TGT);
    chk(rd_q, 32'h5DC, "stage 1");
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_can;
    t_clamp;
    t_fail;
    t_fixed;
    report_and_stop;
  end
  initial begin
    #100000;
    err_count++;
    report_and_stop;
  end
endmodule // speed_request_decoder_bench
`default_nettype wire
